// file: hdl/fbpd_decoder.sv
// What this block does
// - 4K variant: codes 11,10,01,00 give boot start F80,F00,E00,C00, top FFF.
// - 8K variant: boot start 1F80,1F00,1E00,1C00, also reset address, top 1FFF.
// - 16K variant: boot start 3F00,3E00,3C00,3800, top 3FFF.
// - 4K variant: 000-BFF readable during write, C00-FFF blocked.
// - 8K variant: 0000-1BFF readable during write, 1C00-1FFF blocked.
// - 16K variant: 0000-37FF readable during write, 3800-3FFF blocked.
// - 4K variant: 12-bit counter, 32-word pages, word index bits 4:0.
// - 8K variant: 13-bit counter, 64-word pages, word index bits 5:0.
// - 16K variant: 14-bit counter, 64-word pages, word index bits 5:0.
// - counter top bit sits one pointer bit higher: 12, 13 or 14.
// - word index top bit sits at pointer bit 5 or 6.
// - erase and write take the page from the pointer above the word field.
// - buffer fill takes the word from pointer bits 5:1 or 6:1.
// - pointer bits above the page field are ignored.
// - load uses pointer bit zero to pick the byte of the word.
// - erase and write take the page from the pointer, ignoring data.
`timescale 1ns/1ps
`default_nettype none

module fbpd_decoder
  import fbpd_pkg::*;
#(
  parameter int VARIANT = VAR_16K
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        boot_size_select_hi,
  input  wire logic        boot_size_select_lo,
  input  wire logic        req_valid,
  input  wire fbpd_req_t   req,
  input  wire logic [15:0] flash_word,
  output logic             req_ready,
  output logic             resp_valid,
  output fbpd_resp_t       resp,
  output fbpd_map_t        map_out
);

  // ==========================================================
  // variant geometry
  localparam int PC_MSB   = PC_MSB_TBL[VARIANT];
  localparam int PAGE_MSB = PAGE_MSB_TBL[VARIANT];
  localparam int PC_W     = PC_MSB + 1;
  localparam int PG_BITS  = PAGE_MSB + 1;

  localparam logic [PTR_W-1:0] PC_MASK   = PTR_W'((32'h1 << PC_W) - 1);
  localparam logic [PTR_W-1:0] WORD_MASK = PTR_W'((32'h1 << PG_BITS) - 1);

  // ==========================================================
  // pointer decoding helpers
  // pointer bit 0 is the byte select, so the word address is shifted down one
  function automatic logic [ADDR_W-1:0] ptr_to_addr(input logic [PTR_W-1:0] p);
    logic [PTR_W-1:0] t;
    t = (p >> 1) & PC_MASK;
    return t[ADDR_W-1:0];
  endfunction

  function automatic logic [PAGE_W-1:0] ptr_to_page(input logic [PTR_W-1:0] p);
    logic [PTR_W-1:0] t;
    t = ((p >> 1) & PC_MASK) >> PG_BITS;
    return t[PAGE_W-1:0];
  endfunction

  function automatic logic [WORD_W-1:0] ptr_to_word(input logic [PTR_W-1:0] p);
    logic [PTR_W-1:0] t;
    t = (p >> 1) & WORD_MASK;
    return t[WORD_W-1:0];
  endfunction

  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
    return hi ? w[15:8] : w[7:0];
  endfunction

  // ==========================================================
  // fuse synchroniser
  logic [CODE_W-1:0] code_meta_r;
  logic [CODE_W-1:0] code_sync_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      code_meta_r <= '0;
      code_sync_r <= '0;
    end else begin
      code_meta_r <= {boot_size_select_hi, boot_size_select_lo};
      code_sync_r <= code_meta_r;
    end
  end

  // ==========================================================
  // start-up sequence: settle, latch the boot size, then run
  fbpd_state_t       state_r;
  fbpd_state_t       state_nxt;
  logic [1:0]        settle_r;
  logic [1:0]        settle_nxt;
  logic [CODE_W-1:0] code_r;
  logic [CODE_W-1:0] code_nxt;

  always_comb begin
    state_nxt  = state_r;
    settle_nxt = settle_r;
    code_nxt   = code_r;
    unique case (state_r)
      ST_SETTLE: begin
        settle_nxt = settle_r + 2'h1;
        if (settle_r == SETTLE_LAST) begin
          state_nxt = ST_LATCH;
        end
      end
      ST_LATCH: begin
        code_nxt  = code_sync_r;
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r  <= ST_SETTLE;
      settle_r <= 2'h0;
      code_r   <= '0;
    end else begin
      state_r  <= state_nxt;
      settle_r <= settle_nxt;
      code_r   <= code_nxt;
    end
  end

  // ==========================================================
  // section map for the latched boot size
  fbpd_map_t map_comb;
  fbpd_map_t map_r;
  fbpd_map_t map_nxt;

  fbpd_boot_map #(
    .VARIANT (VARIANT)
  ) u_boot_map (
    .code (code_r),
    .map  (map_comb)
  );

  always_comb begin
    map_nxt = map_comb;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      map_r <= '0;
    end else begin
      map_r <= map_nxt;
    end
  end

  assign map_out = map_r;

  // ==========================================================
  // request decode
  logic       req_fire;
  fbpd_resp_t resp_r;
  fbpd_resp_t resp_nxt;
  logic       resp_valid_r;
  logic       resp_valid_nxt;

  assign req_ready = (state_r == ST_RUN);
  assign req_fire  = req_valid && req_ready;

  always_comb begin
    resp_nxt       = resp_r;
    resp_valid_nxt = 1'b0;
    if (req_fire) begin
      resp_valid_nxt              = 1'b1;
      resp_nxt.cmd                = req.cmd;
      resp_nxt.flash_addr         = ptr_to_addr(req.ptr);
      resp_nxt.page_number_field  = ptr_to_page(req.ptr);
      resp_nxt.word_in_page_field = ptr_to_word(req.ptr);
      // map_r lags the latched code by one edge, and the first request may land in that edge
      resp_nxt.in_boot            = ptr_to_addr(req.ptr) >= map_comb.boot_start;
      resp_nxt.in_blocked         = ptr_to_addr(req.ptr) >= map_r.blocked_start;
      resp_nxt.data               = '0;
      resp_nxt.load_byte          = '0;
      resp_nxt.ptr_lsb_set        = 1'b0;
      resp_nxt.word_bits_set      = 1'b0;
      unique case (req.cmd)
        CMD_FILL: begin
          resp_nxt.data        = req.data;
          resp_nxt.ptr_lsb_set = req.ptr[0];
        end
        CMD_ERASE: begin
          resp_nxt.ptr_lsb_set = req.ptr[0];
        end
        CMD_WRITE: begin
          resp_nxt.ptr_lsb_set   = req.ptr[0];
          resp_nxt.word_bits_set = ptr_to_word(req.ptr) != '0;
        end
        CMD_LOAD: begin
          resp_nxt.load_byte = pick_byte(flash_word, req.ptr[0]);
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resp_r       <= '0;
      resp_valid_r <= 1'b0;
    end else begin
      resp_r       <= resp_nxt;
      resp_valid_r <= resp_valid_nxt;
    end
  end

  assign resp       = resp_r;
  assign resp_valid = resp_valid_r;

  // ==========================================================
  // checks
  property p_app_end;
    @(posedge clk) disable iff (rst)
    (state_r == ST_RUN) |-> (map_r.app_end + ADDR_ONE == map_r.boot_start)
      && (map_r.reset_addr == map_r.boot_start);
  endproperty
  a_app_end: assert property (p_app_end) else $error("app end not one below boot start");

  property p_boot_table;
    @(posedge clk) disable iff (rst)
    (state_r == ST_RUN) && $stable(code_r) |-> ##1 map_r.boot_start ==
      ((VARIANT == VAR_4K) ? BOOT_START_4K[$past(code_r)] :
       (VARIANT == VAR_8K) ? BOOT_START_8K[$past(code_r)] : BOOT_START_16K[$past(code_r)]);
  endproperty
  a_boot_table: assert property (p_boot_table) else $error("boot start mismatch");

  property p_top;
    @(posedge clk) disable iff (rst)
    (state_r == ST_RUN) |-> map_r.section_top == SECTION_TOP[VARIANT];
  endproperty
  a_top: assert property (p_top) else $error("section top mismatch");

  property p_blocked;
    @(posedge clk) disable iff (rst)
    resp_valid |-> resp.in_blocked == (resp.flash_addr >= BLOCKED_START[VARIANT]);
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked section flag wrong");

  property p_boot_flag;
    @(posedge clk) disable iff (rst)
    resp_valid |-> resp.in_boot == (resp.flash_addr >= map_r.boot_start);
  endproperty
  a_boot_flag: assert property (p_boot_flag) else $error("boot flag wrong");

  property p_addr;
    @(posedge clk) disable iff (rst)
    req_fire |=> resp_valid && resp.flash_addr == ADDR_W'(($past(req.ptr) >> 1) & PC_MASK);
  endproperty
  a_addr: assert property (p_addr) else $error("word address wrong");

  property p_high_ignored;
    @(posedge clk) disable iff (rst)
    resp_valid |-> (PTR_W'(resp.flash_addr) >> PC_W) == '0;
  endproperty
  a_high_ignored: assert property (p_high_ignored) else $error("high pointer bits leaked");

  property p_page;
    @(posedge clk) disable iff (rst)
    req_fire && (req.cmd == CMD_ERASE) |=>
      resp.page_number_field == PAGE_W'(resp.flash_addr >> PG_BITS) && resp.data == '0;
  endproperty
  a_page: assert property (p_page) else $error("erase page wrong or data kept");

  property p_word;
    @(posedge clk) disable iff (rst)
    req_fire && (req.cmd == CMD_FILL) |=>
      resp.word_in_page_field == WORD_W'($past(req.ptr[WORD_W:1]) & WORD_MASK[WORD_W-1:0]);
  endproperty
  a_word: assert property (p_word) else $error("fill word index wrong");

  property p_byte;
    @(posedge clk) disable iff (rst)
    req_fire && (req.cmd == CMD_LOAD) |=>
      resp.load_byte == ($past(req.ptr[0]) ? $past(flash_word[15:8]) : $past(flash_word[7:0]));
  endproperty
  a_byte: assert property (p_byte) else $error("load byte select wrong");

  property p_ready;
    @(posedge clk) $fell(rst) |-> ##[1:6] req_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("not ready after reset");

endmodule

`default_nettype wire

// file: hdl/fbpd_pkg.sv
package fbpd_pkg;

  // ==========================================================
  // variants and widths
  localparam int VAR_4K  = 0;
  localparam int VAR_8K  = 1;
  localparam int VAR_16K = 2;

  localparam int PTR_W  = 16;
  localparam int ADDR_W = 14;
  localparam int PAGE_W = 8;
  localparam int WORD_W = 6;
  localparam int CODE_W = 2;

  localparam int PC_MSB_TBL   [3] = '{11, 12, 13};
  localparam int PAGE_MSB_TBL [3] = '{4, 5, 5};

  // ==========================================================
  // section maps, boot start indexed by boot-size code
  localparam logic [ADDR_W-1:0] BOOT_START_4K  [4] = '{14'h0C00, 14'h0E00, 14'h0F00, 14'h0F80};
  localparam logic [ADDR_W-1:0] BOOT_START_8K  [4] = '{14'h1C00, 14'h1E00, 14'h1F00, 14'h1F80};
  localparam logic [ADDR_W-1:0] BOOT_START_16K [4] = '{14'h3800, 14'h3C00, 14'h3E00, 14'h3F00};
  localparam logic [ADDR_W-1:0] SECTION_TOP    [3] = '{14'h0FFF, 14'h1FFF, 14'h3FFF};
  localparam logic [ADDR_W-1:0] BLOCKED_START  [3] = '{14'h0C00, 14'h1C00, 14'h3800};
  localparam logic [ADDR_W-1:0] ADDR_ONE           = 14'h0001;

  // ==========================================================
  // timing
  localparam int          SETTLE_CYCLES = 2;
  localparam logic [1:0]  SETTLE_LAST   = 2'(SETTLE_CYCLES - 1);

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    CMD_FILL  = 2'b00,
    CMD_ERASE = 2'b01,
    CMD_WRITE = 2'b10,
    CMD_LOAD  = 2'b11
  } fbpd_cmd_t;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_LATCH  = 2'b01,
    ST_RUN    = 2'b10
  } fbpd_state_t;

  typedef struct packed {
    fbpd_cmd_t          cmd;
    logic [PTR_W-1:0]   ptr;
    logic [15:0]        data;
  } fbpd_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0]  boot_start;
    logic [ADDR_W-1:0]  app_end;
    logic [ADDR_W-1:0]  reset_addr;
    logic [ADDR_W-1:0]  section_top;
    logic [ADDR_W-1:0]  blocked_start;
  } fbpd_map_t;

  typedef struct packed {
    fbpd_cmd_t          cmd;
    logic [PAGE_W-1:0]  page_number_field;
    logic [WORD_W-1:0]  word_in_page_field;
    logic [ADDR_W-1:0]  flash_addr;
    logic [15:0]        data;
    logic [7:0]         load_byte;
    logic               in_boot;
    logic               in_blocked;
    logic               ptr_lsb_set;
    logic               word_bits_set;
  } fbpd_resp_t;

endpackage

// file: hdl/fbpd_boot_map.sv
`timescale 1ns/1ps
`default_nettype none

module fbpd_boot_map
  import fbpd_pkg::*;
#(
  parameter int VARIANT = VAR_16K
) (
  input  wire logic [CODE_W-1:0] code,
  output fbpd_map_t              map
);

  // ==========================================================
  // boot start lookup
  function automatic logic [ADDR_W-1:0] boot_start_of(input logic [CODE_W-1:0] c);
    logic [ADDR_W-1:0] s;
    s = BOOT_START_16K[c];
    if (VARIANT == VAR_4K) begin
      s = BOOT_START_4K[c];
    end else if (VARIANT == VAR_8K) begin
      s = BOOT_START_8K[c];
    end
    return s;
  endfunction

  // ==========================================================
  // section map
  always_comb begin
    map.boot_start    = boot_start_of(code);
    map.reset_addr    = boot_start_of(code);
    map.app_end       = boot_start_of(code) - ADDR_ONE;
    map.section_top   = SECTION_TOP[VARIANT];
    map.blocked_start = BLOCKED_START[VARIANT];
  end

endmodule

`default_nettype wire

// file: dv/fbpd_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// core side: issues program-memory requests
module fbpd_core_model
  import fbpd_pkg::*;
(
  input  wire logic   clk,
  output logic        req_valid,
  output fbpd_req_t   req,
  output logic [15:0] flash_word
);
  initial begin
    req_valid  = 1'b0;
    req        = '0;
    flash_word = 16'h0000;
  end

  // held through the taking edge; pointer exactly as the scenario commands
  task automatic issue(input fbpd_cmd_t c, input logic [15:0] p, input logic [15:0] d, input logic [15:0] w);
    req_valid  <= 1'b1;
    req        <= '{cmd: c, ptr: p, data: d};
    flash_word <= w;
    @(posedge clk);
  endtask

  // released ptr, data and flash_word show the inverse of their last value; cmd keeps its value
  task automatic idle();
    req_valid  <= 1'b0;
    req.ptr    <= ~req.ptr;
    req.data   <= ~req.data;
    flash_word <= ~flash_word;
    @(posedge clk);
  endtask
endmodule

`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import fbpd_pkg::*;
;
  typedef struct packed {
    fbpd_cmd_t   cmd;
    logic [15:0] ptr;
    logic [15:0] d;
    logic [15:0] w;
    logic [7:0]  lb;
    logic        lsb;
    logic        wbs;
  } fbpd_row_t;

  // ==========================================
  // cases: inputs, then expected byte and flags
  localparam fbpd_row_t ROWS [8] = '{
    '{CMD_ERASE, 16'hFFFE, 16'h1234, 16'h0000, 8'h00, 1'b0, 1'b0},
    '{CMD_WRITE, 16'h7F00, 16'h0000, 16'h0000, 8'h00, 1'b0, 1'b0},
    '{CMD_FILL,  16'h007E, 16'hA5C3, 16'h0000, 8'h00, 1'b0, 1'b0},
    '{CMD_LOAD,  16'h1235, 16'h0000, 16'hBEEF, 8'hBE, 1'b0, 1'b0},
    '{CMD_LOAD,  16'h1234, 16'h0000, 16'hBEEF, 8'hEF, 1'b0, 1'b0},
    '{CMD_FILL,  16'h0003, 16'h0F0F, 16'h0000, 8'h00, 1'b1, 1'b0},
    '{CMD_WRITE, 16'h0042, 16'h0000, 16'h0000, 8'h00, 1'b0, 1'b1},
    '{CMD_ERASE, 16'hB801, 16'h0000, 16'h0000, 8'h00, 1'b1, 1'b0}
  };
  localparam int AMSB [3] = '{12, 13, 14};
  localparam int WTOP [3] = '{5, 6, 6};
  localparam int TOPS [3] = '{32'h1000, 32'h2000, 32'h4000};
  localparam int BLK  [3] = '{32'h0C00, 32'h1C00, 32'h3800};
  localparam int BSZ  [3] = '{128, 128, 256};

  logic        clk;
  logic        rst = 1'b1;
  logic [1:0]  fz = 2'b11;
  logic [1:0]  code = 2'b11;
  logic        rdy_exp = 1'b0;
  logic        ev;
  int          cur = 0;
  int          num_errors = 0;
  int          num_checks = 0;
  int          a;
  fbpd_row_t   r;
  logic        req_valid;
  fbpd_req_t   req;
  logic [15:0] flash_word;
  logic        rdy [3];
  logic        rv [3];
  fbpd_resp_t  rs [3];
  fbpd_map_t   mp [3];

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  fbpd_core_model fbpd_core_model_i (
    .clk        (clk),
    .req_valid  (req_valid),
    .req        (req),
    .flash_word (flash_word)
  );

  for (genvar v = 0; v < 3; v++) begin : g_var
    fbpd_decoder #(.VARIANT(v)) fbpd_decoder_i (
      .clk                 (clk),
      .rst                 (rst),
      .boot_size_select_hi (fz[1]),
      .boot_size_select_lo (fz[0]),
      .req_valid           (req_valid),
      .req                 (req),
      .flash_word          (flash_word),
      .req_ready           (rdy[v]),
      .resp_valid          (rv[v]),
      .resp                (rs[v]),
      .map_out             (mp[v])
    );
  end

  // ==========================================
  // checking
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  function automatic int bstart(input int v);
    return TOPS[v] - (BSZ[v] << (3 - int'(code)));
  endfunction

  task automatic chkmap();
    for (int v = 0; v < 3; v++) begin
      chk("boot_start", 16'(bstart(v)), mp[v].boot_start);
      chk("app_end", 16'(bstart(v) - 1), mp[v].app_end);
      chk("reset_addr", 16'(bstart(v)), mp[v].reset_addr);
      chk("section_top", 16'(TOPS[v] - 1), mp[v].section_top);
      chk("blocked_start", 16'(BLK[v]), mp[v].blocked_start);
    end
  endtask

  // expectation taken from what stood before the edge
  always @(posedge clk) begin
    ev = req_valid & rdy_exp;
    r = ROWS[cur];
    #1;
    for (int v = 0; v < 3; v++) begin
      chk("req_ready", rdy_exp, rdy[v]);
      chk("resp_valid", ev, rv[v]);
      if (ev) begin
        a = (r.ptr >> 1) & ((1 << AMSB[v]) - 1);
        chk("cmd", r.cmd, rs[v].cmd);
        chk("flash_addr", 16'(a), rs[v].flash_addr);
        chk("page", 16'(a >> WTOP[v]), rs[v].page_number_field);
        chk("word", 16'(a & ((1 << WTOP[v]) - 1)), rs[v].word_in_page_field);
        chk("data", (r.cmd == CMD_FILL) ? r.d : 16'h0000, rs[v].data);
        chk("load_byte", r.lb, rs[v].load_byte);
        chk("in_boot", a >= bstart(v), rs[v].in_boot);
        chk("in_blocked", a >= BLK[v], rs[v].in_blocked);
        chk("ptr_lsb_set", r.lsb, rs[v].ptr_lsb_set);
        chk("word_bits_set", r.wbs, rs[v].word_bits_set);
      end
    end
  end

  task automatic conclude();
    if (num_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    conclude();
  end

  // ==========================================
  // every boot-size code; request during reset is refused
  initial begin
    for (int c = 0; c < 4; c++) begin
      rst  <= 1'b1;
      code <= 2'(3 - c);
      fz   <= 2'(3 - c);
      @(posedge clk);
      rdy_exp <= 1'b0;
      fbpd_core_model_i.issue(CMD_ERASE, 16'h3F00, 16'h0000, 16'h0000);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      fbpd_core_model_i.idle();
      repeat (2) @(posedge clk);
      rdy_exp <= 1'b1;
      repeat (2) @(posedge clk);
      chkmap();
      // fuse change after latching must not move the map
      fz <= ~fz;
      for (int i = 0; i < 8; i++) begin
        cur <= i;
        fbpd_core_model_i.issue(ROWS[i].cmd, ROWS[i].ptr, ROWS[i].d, ROWS[i].w);
      end
      fbpd_core_model_i.idle();
      repeat (3) @(posedge clk);
      chkmap();
    end
    // ==========================================
    // first request taken on the very edge after ready rises, boot size just latched
    rst  <= 1'b1;
    code <= 2'b11;
    fz   <= 2'b11;
    @(posedge clk);
    rdy_exp <= 1'b0;
    cur     <= 7;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rdy_exp <= 1'b1;
    fbpd_core_model_i.issue(ROWS[7].cmd, ROWS[7].ptr, ROWS[7].d, ROWS[7].w);
    fbpd_core_model_i.idle();
    repeat (2) @(posedge clk);
    chkmap();
    conclude();
  end
endmodule

`default_nettype wire
